/* File: core/wsc_wake_regs.v */
// Wake source control register bank: peak threshold, internal and
// external wake control registers, with their derived control levels.
// Assumes a serial control port front end that delivers decoded byte
// accesses, and a mode controller on the same clock reporting the mode.
//
// How it works
// - Peak register bit five picks threshold
// - Peak bit writable only in Init/Normal
// - Stop mode: peak write silently ignored
// - Reserved bits always read zero
// - Internal bit seven enables second timer
// - Internal bit six enables first timer
// - Bit two: watchdog off in Stop
// - External bit seven sets interrupt scope
// - Measure bit gates pins one, two
// - Measure selected: pin levels invalid
// - Bits two..zero enable wake pins
// - Reset loads zeros, zeros, pin enables
// - Restart entry keeps listed bits only
// - Fail-safe entry by failure forces wake patterns
// - Transceiver mode field codes decoded
`timescale 1ns/1ns
`include "wsc_defs.vh"

module wsc_wake_regs (
   // Clock and reset
   input  wire                   i_sys_clk,
   input  wire                   i_reset_n,
   input  wire                   i_soft_rst,
   // Decoded register access
   input  wire                   i_acc_valid,
   input  wire                   i_acc_write,
   input  wire [`WSC_ADDR_W-1:0] i_acc_addr,
   input  wire [7:0]             i_acc_wdata,
   output reg                    o_acc_ack,
   output reg                    o_acc_hit,
   output reg  [7:0]             o_acc_rdata,
   // Device mode and failure cause
   input  wire [`WSC_MODE_W-1:0] i_sbc_mode,
   input  wire                   i_fail_cause,
   // Device update of the watchdog stop bit
   input  wire                   i_wdoff_we,
   input  wire                   i_wdoff_val,
   // Transceiver mode field seen in the bus mode register
   input  wire [2:0]             i_can_mode,
   // Control levels
   output reg                    o_peak_threshold_select,
   output reg                    o_second_timer_wake_enable,
   output reg                    o_first_timer_wake_enable,
   output reg                    o_stop_mode_watchdog_off_bit1,
   output reg                    o_int_global,
   output reg                    o_pin_measure_select,
   output reg                    o_meas_active,
   output reg  [2:0]             o_pin_wake_enable,
   output reg                    o_pin_level_valid,
   output reg                    o_can_wake_source,
   output reg                    o_can_selective_wake,
   // Fail-safe force of the bus mode register
   output reg                    o_bus_force_stb,
   output reg  [7:0]             o_bus_force_mask,
   output reg  [7:0]             o_bus_force_val
);

   ////////////////////////////////////////////////////////////////////////
   // Per-register constants, indexed 0 peak, 1 internal, 2 external

   // Address of register index
   function [`WSC_ADDR_W-1:0] f_addr;
      input integer idx;
      begin
         case (idx)
            0:       f_addr = `WSC_ADDR_PEAK;
            1:       f_addr = `WSC_ADDR_INTWK;
            default: f_addr = `WSC_ADDR_EXTWK;
         endcase
      end
   endfunction

   // Reset value of register index
   function [7:0] f_rst;
      input integer idx;
      begin
         case (idx)
            0:       f_rst = `WSC_RST_PEAK;
            1:       f_rst = `WSC_RST_INTWK;
            default: f_rst = `WSC_RST_EXTWK;
         endcase
      end
   endfunction

   // Restart keep mask of register index
   function [7:0] f_keep;
      input integer idx;
      begin
         case (idx)
            0:       f_keep = `WSC_KEEP_PEAK;
            1:       f_keep = `WSC_KEEP_INTWK;
            default: f_keep = `WSC_KEEP_EXTWK;
         endcase
      end
   endfunction

   // Writable-bit mask of register index
   function [7:0] f_wmask;
      input integer idx;
      begin
         case (idx)
            0:       f_wmask = `WSC_WM_PEAK;
            1:       f_wmask = `WSC_WM_INTWK;
            default: f_wmask = `WSC_WM_EXTWK;
         endcase
      end
   endfunction

   // Fail-safe forced-bit mask of register index
   function [7:0] f_fsmask;
      input integer idx;
      begin
         case (idx)
            2:       f_fsmask = `WSC_FS_MASK_EXTWK;
            default: f_fsmask = `WSC_FS_MASK_NONE;
         endcase
      end
   endfunction

   // Device-updated bits of register index
   function [7:0] f_hwmask;
      input integer idx;
      begin
         case (idx)
            1:       f_hwmask = 8'h01 << `WSC_B_WDOFF1;
            default: f_hwmask = 8'h00;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Mode tracking and entry events

   reg  [`WSC_MODE_W-1:0] mode_r;      // Mode seen last cycle
   wire                   restart_ent; // First cycle in restart mode
   wire                   fs_ent;      // First cycle in fail-safe by failure
   wire                   wr_open;     // Peak bit accepts writes

   // Previous mode, to find mode entries
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         mode_r <= `WSC_MODE_INIT;
      end else begin
         mode_r <= i_sbc_mode;
      end
   end

   assign restart_ent = (i_sbc_mode == `WSC_MODE_RESTART) &&
                        (mode_r != `WSC_MODE_RESTART);
   assign fs_ent      = (i_sbc_mode == `WSC_MODE_FAILSAFE) &&
                        (mode_r != `WSC_MODE_FAILSAFE) && i_fail_cause;

   // Peak bit is writable in Init and Normal only; Stop drops it quietly
   assign wr_open = (i_sbc_mode == `WSC_MODE_INIT) ||
                    (i_sbc_mode == `WSC_MODE_NORMAL);

   ////////////////////////////////////////////////////////////////////////
   // Register instances

   wire [7:0] reg_q [0:`WSC_NREG-1];  // Stored register bytes
   wire [7:0] hw_data;                // Device update of watchdog bit

   assign hw_data = {7'h00, i_wdoff_val} << `WSC_B_WDOFF1;

   genvar gi;
   generate
      for (gi = 0; gi < `WSC_NREG; gi = gi + 1) begin : g_reg
         wire       we;      // Host write to this register
         wire [7:0] wmask;   // Bits the host may change now

         assign we    = i_acc_valid && i_acc_write && (i_acc_addr == f_addr(gi));
         // Reserved bits are never in the mask, peak bit gated by mode
         assign wmask = (gi == 0 && !wr_open) ? 8'h00 : f_wmask(gi);

         wsc_reg8 #(
            .RST_VAL (f_rst(gi)),
            .KEEP    (f_keep(gi)),
            .FS_MASK (f_fsmask(gi)),
            .FS_VAL  (`WSC_FS_VAL_EXTWK),
            .HW_MASK (f_hwmask(gi))
         ) u_reg (
            .i_sys_clk  (i_sys_clk),
            .i_reset_n  (i_reset_n),
            .i_soft_rst (i_soft_rst),
            .i_we       (we),
            .i_wmask    (wmask),
            .i_wdata    (i_acc_wdata),
            .i_restart  (restart_ent),
            .i_failsafe (fs_ent),
            .i_hw_we    (i_wdoff_we),
            .i_hw_data  (hw_data),
            .o_q        (reg_q[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read path: one-cycle answer, data from flip-flops

   reg [7:0] rd_nxt;  // Selected read byte
   reg       hit_nxt; // Address belongs to this bank

   // Address decode for reads; reserved bits masked to zero
   always @* begin
      rd_nxt  = 8'h00;
      hit_nxt = 1'b1;
      case (i_acc_addr)
         `WSC_ADDR_PEAK:  rd_nxt = reg_q[0] & f_wmask(0);
         `WSC_ADDR_INTWK: rd_nxt = reg_q[1] & f_wmask(1);
         `WSC_ADDR_EXTWK: rd_nxt = reg_q[2] & f_wmask(2);
         default:         hit_nxt = 1'b0;
      endcase
   end

   // Acknowledge and read data one cycle after the access
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_acc_ack   <= 1'b0;
         o_acc_hit   <= 1'b0;
         o_acc_rdata <= 8'h00;
      end else begin
         o_acc_ack <= i_acc_valid;
         if (i_acc_valid) begin
            o_acc_hit   <= hit_nxt;
            o_acc_rdata <= rd_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Derived control levels

   wire       meas;     // Measurement selected
   wire [2:0] pin_en;   // Raw pin enables
   wire [1:0] can_fn;   // Transceiver function without selective bit

   assign meas   = reg_q[2][`WSC_B_MEAS];
   assign pin_en = {reg_q[2][`WSC_B_PIN3], reg_q[2][`WSC_B_PIN2],
                    reg_q[2][`WSC_B_PIN1]};
   assign can_fn = i_can_mode[1:0];

   // Control outputs, registered
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_peak_threshold_select       <= 1'b0;
         o_second_timer_wake_enable    <= 1'b0;
         o_first_timer_wake_enable     <= 1'b0;
         o_stop_mode_watchdog_off_bit1 <= 1'b0;
         o_int_global                  <= 1'b0;
         o_pin_measure_select          <= 1'b0;
         o_meas_active                 <= 1'b0;
         o_pin_wake_enable             <= 3'h0;
         o_pin_level_valid             <= 1'b0;
         o_can_wake_source             <= 1'b0;
         o_can_selective_wake          <= 1'b0;
      end else begin
         o_peak_threshold_select       <= reg_q[0][`WSC_B_PEAK];
         o_second_timer_wake_enable    <= reg_q[1][`WSC_B_T2WK];
         o_first_timer_wake_enable     <= reg_q[1][`WSC_B_T1WK];
         o_stop_mode_watchdog_off_bit1 <= reg_q[1][`WSC_B_WDOFF1];
         o_int_global                  <= reg_q[2][`WSC_B_INTGLB];
         o_pin_measure_select          <= meas;
         // Measurement runs only in Normal mode
         o_meas_active <= meas && (i_sbc_mode == `WSC_MODE_NORMAL);
         // Pins one and two lose their enables under measurement
         o_pin_wake_enable <= {pin_en[2], pin_en[1:0] & {2{~meas}}};
         // Pin level status meaningless while measuring
         o_pin_level_valid <= ~meas;
         // Bus wakes only when the host chose a wake-capable mode
         o_can_wake_source    <= (can_fn == `WSC_CAN_WAKE);
         o_can_selective_wake <= i_can_mode[`WSC_CAN_B_SWK] &&
                                 (can_fn != `WSC_CAN_OFF);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fail-safe force of the bus mode register (held elsewhere)

   // One-cycle strobe with the forced pattern and its mask
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_bus_force_stb  <= 1'b0;
         o_bus_force_mask <= 8'h00;
         o_bus_force_val  <= 8'h00;
      end else begin
         o_bus_force_stb  <= fs_ent;
         o_bus_force_mask <= `WSC_FS_MASK_BUS;
         o_bus_force_val  <= `WSC_FS_VAL_BUS;
      end
   end

endmodule

/* File: shared/wsc_defs.vh */
// Constants for the wake source control register bank.
// Assumes one includer per compile unit; guarded against double inclusion.
`ifndef WSC_DEFS_VH
`define WSC_DEFS_VH

// Register addresses on the serial control port
`define WSC_ADDR_W          7
`define WSC_ADDR_PEAK       7'h05
`define WSC_ADDR_INTWK      7'h06
`define WSC_ADDR_EXTWK      7'h07
`define WSC_NREG            3

// Device operating modes, as driven by the mode controller
`define WSC_MODE_W          3
`define WSC_MODE_INIT       3'h0
`define WSC_MODE_NORMAL     3'h1
`define WSC_MODE_STOP       3'h2
`define WSC_MODE_SLEEP      3'h3
`define WSC_MODE_RESTART    3'h4
`define WSC_MODE_FAILSAFE   3'h5

// Field positions
`define WSC_B_PEAK          5
`define WSC_B_T2WK          7
`define WSC_B_T1WK          6
`define WSC_B_WDOFF1        2
`define WSC_B_INTGLB        7
`define WSC_B_MEAS          5
`define WSC_B_PIN3          2
`define WSC_B_PIN2          1
`define WSC_B_PIN1          0

// Power-on / soft reset values
`define WSC_RST_PEAK        8'h00
`define WSC_RST_INTWK       8'h00
`define WSC_RST_EXTWK       8'h07

// Writable bits; everything else is reserved and reads zero
`define WSC_WM_PEAK         8'h20
`define WSC_WM_INTWK        8'hC4
`define WSC_WM_EXTWK        8'hA7

// Bits kept on entry to restart mode
`define WSC_KEEP_PEAK       8'h20
`define WSC_KEEP_INTWK      8'hC0
`define WSC_KEEP_EXTWK      8'hA7

// Fail-safe forced pattern: mask of forced bits and their value
`define WSC_FS_MASK_EXTWK   8'h5F
`define WSC_FS_VAL_EXTWK    8'h07
`define WSC_FS_MASK_NONE    8'h00
`define WSC_FS_MASK_BUS     8'h1F
`define WSC_FS_VAL_BUS      8'h09

// Bus transceiver mode field codes
`define WSC_CAN_OFF         2'h0
`define WSC_CAN_WAKE        2'h1
`define WSC_CAN_RXONLY      2'h2
`define WSC_CAN_NORMAL      2'h3
`define WSC_CAN_B_SWK       2

`endif

/* File: core/wsc_reg8.v */
// One 8-bit control register with reset, restart and fail-safe loads.
// Assumes write strobe, masks and mode events come from the same clock.
`timescale 1ns/1ns

module wsc_reg8 #(
   parameter [7:0] RST_VAL  = 8'h00,   // Power-on / soft reset value
   parameter [7:0] KEEP     = 8'h00,   // Bits kept on restart entry
   parameter [7:0] FS_MASK  = 8'h00,   // Bits forced on fail-safe entry
   parameter [7:0] FS_VAL   = 8'h00,   // Values of forced bits
   parameter [7:0] HW_MASK  = 8'h00    // Bits the device may update
) (
   // Clock and reset
   input  wire       i_sys_clk,
   input  wire       i_reset_n,
   input  wire       i_soft_rst,
   // Host write
   input  wire       i_we,
   input  wire [7:0] i_wmask,
   input  wire [7:0] i_wdata,
   // Mode events
   input  wire       i_restart,
   input  wire       i_failsafe,
   // Device update
   input  wire       i_hw_we,
   input  wire [7:0] i_hw_data,
   // Stored value
   output wire [7:0] o_q
);

   reg [7:0] q_r;     // Stored byte
   reg [7:0] q_nxt;   // Next value

   assign o_q = q_r;

   ////////////////////////////////////////////////////////////////////////
   // Next value: reset, then fail-safe, restart, device update, host write
   always @* begin
      q_nxt = q_r;
      if (i_soft_rst) begin
         q_nxt = RST_VAL;
      end else if (i_failsafe) begin
         q_nxt = (q_r & ~FS_MASK) | (FS_VAL & FS_MASK);
      end else if (i_restart) begin
         q_nxt = q_r & KEEP;
      end else begin
         // Host write touches writable bits only
         if (i_we) begin
            q_nxt = (q_r & ~i_wmask) | (i_wdata & i_wmask);
         end
         // Device update wins over a host write in the same cycle
         if (i_hw_we) begin
            q_nxt = (q_nxt & ~HW_MASK) | (i_hw_data & HW_MASK);
         end
      end
   end

   // Register with synchronous reset
   always @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         q_r <= RST_VAL;
      end else begin
         q_r <= q_nxt;
      end
   end

endmodule

/* File: bench/wsc_host.sv */
// Host model: issues one byte access at a time on the access port.
// Assumes requests are driven 1 ns after the rising clock edge.
`timescale 1ns/1ns
module wsc_host (
   // Clock and answer
   input  wire       i_sys_clk,
   input  wire       i_acc_ack,
   input  wire [7:0] i_acc_rdata,
   // Request
   output reg        o_acc_valid,
   output reg        o_acc_write,
   output reg  [6:0] o_acc_addr,
   output reg  [7:0] o_acc_wdata
);
   // Idle at time zero
   initial begin
      o_acc_valid = 1'b0;
      o_acc_write = 1'b0;
      o_acc_addr  = 7'h00;
      o_acc_wdata = 8'h00;
   end
   // One access: valid for one cycle, answer taken in the cycle after
   task acc(input w, input [6:0] a, input [7:0] d, output [7:0] q, output k);
      begin
         o_acc_valid = 1'b1;
         o_acc_write = w;
         o_acc_addr  = a;
         o_acc_wdata = d;
         @(posedge i_sys_clk);
         #1;
         q = i_acc_rdata;
         k = i_acc_ack;
         // Released lines show junk, not the last value
         o_acc_valid = 1'b0;
         o_acc_addr  = ~a;
         o_acc_wdata = ~d;
         @(posedge i_sys_clk);
         #1;
      end
   endtask
endmodule

/* File: bench/wsc_wake_chk.sv */
// Checker on the wake register bank ports.
// Assumes it is bound to wsc_wake_regs; one clock domain.
`timescale 1ns/1ns
module wsc_wake_chk (
   // Clock, reset and inputs
   input wire       i_sys_clk,
   input wire       i_reset_n,
   input wire       i_soft_rst,
   input wire       i_acc_valid,
   input wire       i_acc_write,
   input wire [6:0] i_acc_addr,
   input wire [7:0] i_acc_wdata,
   input wire [2:0] i_sbc_mode,
   input wire       i_fail_cause,
   input wire       i_wdoff_we,
   input wire [2:0] i_can_mode,
   // Outputs
   input wire       o_acc_ack,
   input wire [7:0] o_acc_rdata,
   input wire       o_peak_threshold_select,
   input wire       o_stop_mode_watchdog_off_bit1,
   input wire       o_pin_measure_select,
   input wire       o_meas_active,
   input wire [2:0] o_pin_wake_enable,
   input wire       o_pin_level_valid,
   input wire       o_can_wake_source,
   input wire       o_can_selective_wake,
   input wire       o_bus_force_stb,
   input wire [7:0] o_bus_force_mask,
   input wire [7:0] o_bus_force_val
);
   reg  [2:0] mode_r;   // Mode one cycle back
   wire       rs_ent;   // Restart entry
   wire       fs_ent;   // Fail-safe entry by failure
   ////////////////////////////////////////
   // Mode history for entry detection
   always @(posedge i_sys_clk) begin
      mode_r <= i_sbc_mode;
   end
   assign rs_ent = i_sbc_mode == 3'h4 && mode_r != 3'h4 && !i_soft_rst;
   assign fs_ent = i_sbc_mode == 3'h5 && mode_r != 3'h5 && i_fail_cause;
   default clocking @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////
   AST_RSVD: assert property (o_acc_ack |->
      (o_acc_rdata & ($past(i_acc_addr) == 7'h05 ? 8'hDF : 8'h18)) == 8'h00)
      else $error("reserved bits read nonzero");
   AST_PEAK_WR: assert property (i_acc_valid && i_acc_write && i_acc_addr == 7'h05 &&
      i_sbc_mode <= 3'h1 && !i_soft_rst |=> ##1
      o_peak_threshold_select == $past(i_acc_wdata[5], 2))
      else $error("peak write not applied");
   AST_STOP: assert property (i_sbc_mode == 3'h2 && !i_soft_rst |=>
      $stable(o_peak_threshold_select))
      else $error("peak bit changed in stop");
   AST_MEAS: assert property (o_pin_measure_select |->
      o_pin_wake_enable[1:0] == 2'b00)
      else $error("pins one two enabled while measuring");
   AST_LVL: assert property ($past(i_reset_n) |->
      o_pin_level_valid != o_pin_measure_select)
      else $error("level valid wrong");
   AST_MACT: assert property ($past(i_reset_n) |-> o_meas_active ==
      (o_pin_measure_select && $past(i_sbc_mode) == 3'h1))
      else $error("measure active wrong");
   AST_RST: assert property (rs_ent ##1 !(i_soft_rst || i_wdoff_we || i_acc_valid) |=>
      $stable(o_peak_threshold_select) && !o_stop_mode_watchdog_off_bit1)
      else $error("restart values wrong");
   AST_FS: assert property (fs_ent |=>
      o_bus_force_stb ##1 o_pin_wake_enable[2])
      else $error("fail-safe force missing");
   AST_FS_ONLY: assert property (o_bus_force_stb |-> $past(fs_ent))
      else $error("stray force strobe");
   AST_FSVAL: assert property ($past(i_reset_n) |->
      o_bus_force_mask == 8'h1F && o_bus_force_val == 8'h09)
      else $error("force pattern wrong");
   AST_CAN: assert property ($past(i_reset_n) |->
      o_can_wake_source == ($past(i_can_mode[1:0]) == 2'h1) &&
      o_can_selective_wake == ($past(i_can_mode[2]) && $past(i_can_mode[1:0]) != 2'h0))
      else $error("transceiver decode wrong");
   // Main scenarios reached
   C_RS: cover property (rs_ent);
   C_FS: cover property (fs_ent);
   C_STOP: cover property (i_acc_valid && i_acc_write && i_acc_addr == 7'h05 && i_sbc_mode == 3'h2);
endmodule
bind wsc_wake_regs wsc_wake_chk u_chk (.*);

/* File: bench/tb_top.sv */
// Self-checking bench for the wake register bank.
// Assumes the bound checker and the host model on the access port.
`timescale 1ns/1ns
`include "wsc_defs.vh"
module tb_top;
   // Design ports, named as the design names them
   reg        i_sys_clk, i_reset_n, i_soft_rst, i_fail_cause, i_wdoff_we, i_wdoff_val;
   reg  [2:0] i_sbc_mode, i_can_mode;
   wire       i_acc_valid, i_acc_write, o_acc_ack, o_acc_hit;
   wire [6:0] i_acc_addr;
   wire [7:0] i_acc_wdata, o_acc_rdata, o_bus_force_mask, o_bus_force_val;
   wire       o_peak_threshold_select, o_second_timer_wake_enable, o_first_timer_wake_enable;
   wire       o_stop_mode_watchdog_off_bit1, o_int_global, o_pin_measure_select;
   wire       o_meas_active, o_pin_level_valid, o_can_wake_source, o_can_selective_wake;
   wire       o_bus_force_stb;
   wire [2:0] o_pin_wake_enable;
   // Bench state
   integer    error_cnt = 0;
   integer    tests_run = 0;
   integer    cyc = 0;
   integer    i;
   reg  [7:0] q;
   reg        k;
   ////////////////////////////////////////
   wsc_wake_regs dut (.*);
   wsc_host host (
      .i_sys_clk   (i_sys_clk),
      .i_acc_ack   (o_acc_ack),
      .i_acc_rdata (o_acc_rdata),
      .o_acc_valid (i_acc_valid),
      .o_acc_write (i_acc_write),
      .o_acc_addr  (i_acc_addr),
      .o_acc_wdata (i_acc_wdata)
   );
   ////////////////////////////////////////
   task check(input [7:0] seen, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge i_sys_clk);
         #1;
      end
   endtask
   task wr(input [6:0] a, input [7:0] d);
      host.acc(1'b1, a, d, q, k);
   endtask
   // Read and compare, answer must come with ack
   task rd(input [6:0] a, input [7:0] e);
      begin
         host.acc(1'b0, a, 8'h00, q, k);
         check(q, e);
         check({7'h0, k}, 8'h01);
         check({7'h0, o_acc_hit}, {7'h0, (a >= 7'h05) && (a <= 7'h07)});
      end
   endtask
   task done(input [8*14-1:0] n);
      $display("test %0s done", n);
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", tests_run, error_cnt);
         if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   ////////////////////////////////////////
   // Clock and hang guard
   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         error_cnt = error_cnt + 1;
         final_report;
      end
   end
   // Main sequence
   initial begin
      {i_reset_n, i_soft_rst, i_fail_cause, i_wdoff_we, i_wdoff_val} = 5'h00;
      i_sbc_mode = `WSC_MODE_INIT;
      i_can_mode = 3'h1;
      tick(6);
      i_reset_n = 1'b1;
      tick(1);
      rd(7'h05, 8'h00);
      rd(7'h06, 8'h00);
      rd(7'h07, 8'h07);
      check({5'h0, o_pin_wake_enable}, 8'h07);
      done("reset");
      i_sbc_mode = `WSC_MODE_NORMAL;
      wr(7'h05, 8'hFF);
      rd(7'h05, 8'h20);
      wr(7'h06, 8'hFF);
      rd(7'h06, 8'hC4);
      wr(7'h07, 8'hFF);
      rd(7'h07, 8'hA7);
      check({7'h0, o_peak_threshold_select}, 8'h01);
      check({6'h0, o_second_timer_wake_enable, o_first_timer_wake_enable}, 8'h03);
      check({6'h0, o_int_global, o_stop_mode_watchdog_off_bit1}, 8'h03);
      check({5'h0, o_pin_measure_select, o_meas_active, o_pin_level_valid}, 8'h06);
      check({5'h0, o_pin_wake_enable}, 8'h04);
      for (i = 0; i < 3; i = i + 1) begin
         wr(7'h07, 8'h01 << i);
         check({5'h0, o_pin_wake_enable}, 8'h01 << i);
      end
      wr(7'h06, 8'h80);
      check({6'h0, o_second_timer_wake_enable, o_first_timer_wake_enable}, 8'h02);
      wr(7'h06, 8'h40);
      check({6'h0, o_second_timer_wake_enable, o_first_timer_wake_enable}, 8'h01);
      wr(7'h05, 8'h00);
      // Stop and Sleep refuse the peak bit
      for (i = 2; i < 4; i = i + 1) begin
         i_sbc_mode = i[2:0];
         wr(7'h05, 8'h20);
         rd(7'h05, 8'h00);
      end
      i_sbc_mode = `WSC_MODE_INIT;
      wr(7'h05, 8'h20);
      rd(7'h05, 8'h20);
      done("write");
      i_sbc_mode = `WSC_MODE_NORMAL;
      wr(7'h06, 8'hC4);
      wr(7'h07, 8'hFF);
      i_sbc_mode = `WSC_MODE_RESTART;
      tick(2);
      rd(7'h05, 8'h20);
      rd(7'h06, 8'hC0);
      rd(7'h07, 8'hA7);
      done("restart");
      i_sbc_mode = `WSC_MODE_NORMAL;
      wr(7'h07, 8'hA0);
      i_sbc_mode = `WSC_MODE_FAILSAFE;
      i_fail_cause = 1'b1;
      tick(1);
      check({7'h0, o_bus_force_stb}, 8'h01);
      i_fail_cause = 1'b0;
      tick(1);
      check({7'h0, o_bus_force_stb}, 8'h00);
      check(o_bus_force_mask, 8'h1F);
      check(o_bus_force_val, 8'h09);
      rd(7'h07, 8'hA7);
      // Fail-safe without a failure forces nothing
      i_sbc_mode = `WSC_MODE_NORMAL;
      wr(7'h07, 8'h00);
      i_sbc_mode = `WSC_MODE_FAILSAFE;
      tick(3);
      check({7'h0, o_bus_force_stb}, 8'h00);
      rd(7'h07, 8'h00);
      done("failsafe");
      i_sbc_mode = `WSC_MODE_NORMAL;
      i_wdoff_val = 1'b1;
      i_wdoff_we = 1'b1;
      tick(1);
      i_wdoff_we = 1'b0;
      tick(1);
      check({7'h0, o_stop_mode_watchdog_off_bit1}, 8'h01);
      rd(7'h06, 8'hC4);
      for (i = 0; i < 8; i = i + 1) begin
         i_can_mode = i[2:0];
         tick(2);
         q = {6'h0, i[2] && i[1:0] != 2'h0, i[1:0] == 2'h1};
         check({6'h0, o_can_selective_wake, o_can_wake_source}, q);
      end
      i_can_mode = 3'h1;
      done("device");
      rd(7'h08, 8'h00);
      check({7'h0, o_acc_hit}, 8'h00);
      i_soft_rst = 1'b1;
      tick(1);
      i_soft_rst = 1'b0;
      rd(7'h05, 8'h00);
      rd(7'h06, 8'h00);
      rd(7'h07, 8'h07);
      done("unmapped_soft");
      final_report;
   end
endmodule
